// ---- design/lhp_port.sv ----
// Host command and data port with parallel and serial capture.
`timescale 1ns/100ps
`default_nettype none
module lhp_port
  import lhp_pkg::*;
(
  input  wire logic        pclk,        // System clock.
  input  wire logic        presetn,     // System reset, active low.
  input  wire logic        psel,        // APB select.
  input  wire logic        penable,     // APB access phase.
  input  wire logic        pwrite,      // APB direction.
  input  wire logic [7:0]  paddr,       // APB byte address.
  input  wire logic [31:0] pwdata,      // APB write data.
  output logic      [31:0] prdata,      // APB read data.
  output logic             pready,      // APB ready.
  output logic             pslverr,     // APB error.
  input  wire logic        link_clk,    // Host strobe: clock, write or sck.
  input  wire logic        reset_n_pin, // Device reset pin, active low.
  input  wire logic        par_sel,     // High parallel, low serial.
  input  wire logic        m68_sel,     // High 6800-style, low 80-style.
  input  wire logic        dc_pin,      // High data, low command.
  input  wire logic        ce_n,        // Chip select, active low.
  input  wire logic        rw_rd_n,     // Direction or read strobe.
  input  wire logic [7:0]  d_in,        // Data pins in, d_in[0] is sda.
  output logic      [7:0]  d_out,       // Data pins out.
  output logic             d_oe         // Data pin drive enable.
);

  // ****************************************************************
  // Link domain capture
  // ****************************************************************
  logic [7:0] p68_byte_reg;
  logic       p68_dc_reg;
  logic       p68_tog_reg;
  logic [7:0] p80_byte_reg;
  logic       p80_dc_reg;
  logic       p80_tog_reg;
  logic [6:0] ser_shift_reg;
  logic [2:0] ser_cnt_reg;
  logic       ser_dcs_reg;
  logic [7:0] ser_byte_reg;
  logic       ser_dc_reg;
  logic       ser_tog_reg;
  logic       ser_rst_n;

  // The 6800-style bus latches a write on the falling clock edge.
  always_ff @(negedge link_clk or negedge reset_n_pin) begin
    if (!reset_n_pin) begin
      p68_byte_reg <= 8'h00;
      p68_dc_reg   <= 1'b0;
      p68_tog_reg  <= 1'b0;
    end else if (par_sel && m68_sel && !ce_n && !rw_rd_n) begin
      p68_byte_reg <= d_in;
      p68_dc_reg   <= dc_pin;
      p68_tog_reg  <= ~p68_tog_reg;
    end
  end

  // The 80-style bus latches a write on the rising write strobe edge.
  always_ff @(posedge link_clk or negedge reset_n_pin) begin
    if (!reset_n_pin) begin
      p80_byte_reg <= 8'h00;
      p80_dc_reg   <= 1'b0;
      p80_tog_reg  <= 1'b0;
    end else if (par_sel && !m68_sel && !ce_n && rw_rd_n) begin
      p80_byte_reg <= d_in;
      p80_dc_reg   <= dc_pin;
      p80_tog_reg  <= ~p80_tog_reg;
    end
  end

  // Deselecting the chip realigns the serial bit count to a byte start.
  assign ser_rst_n = reset_n_pin & ~ce_n;

  // The serial shifter takes sda MSB first on each falling edge.
  always_ff @(negedge link_clk or negedge ser_rst_n) begin
    if (!ser_rst_n) begin
      ser_shift_reg <= 7'h00;
      ser_cnt_reg   <= 3'h0;
      ser_dcs_reg   <= 1'b0;
    end else if (!par_sel) begin
      ser_shift_reg <= {ser_shift_reg[5:0], d_in[0]};
      ser_cnt_reg   <= ser_cnt_reg + 3'h1;
      if (ser_cnt_reg == 3'h0) begin
        ser_dcs_reg <= dc_pin;
      end
    end
  end

  // A full serial byte is held here so that it survives deselection.
  always_ff @(negedge link_clk or negedge reset_n_pin) begin
    if (!reset_n_pin) begin
      ser_byte_reg <= 8'h00;
      ser_dc_reg   <= 1'b0;
      ser_tog_reg  <= 1'b0;
    end else if (!par_sel && !ce_n && ser_cnt_reg == LHP_SER_LAST) begin
      ser_byte_reg <= {ser_shift_reg, d_in[0]};
      ser_dc_reg   <= ser_dcs_reg;
      ser_tog_reg  <= ~ser_tog_reg;
    end
  end

  // ****************************************************************
  // Crossing into the system clock
  // ****************************************************************
  logic [2:0] tog_s1_reg;
  logic [2:0] tog_s2_reg;
  logic [2:0] tog_s3_reg;
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic [1:0] strap_s1_reg;
  logic [1:0] strap_s2_reg;
  logic [2:0] tog_evt;

  // Toggles pass two flops; the third keeps the old level for edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_s1_reg <= 3'h0;
      tog_s2_reg <= 3'h0;
      tog_s3_reg <= 3'h0;
    end else begin
      tog_s1_reg <= {ser_tog_reg, p80_tog_reg, p68_tog_reg};
      tog_s2_reg <= tog_s1_reg;
      tog_s3_reg <= tog_s2_reg;
    end
  end

  assign tog_evt = tog_s2_reg ^ tog_s3_reg;

  // Pin levels: chip select, direction or read strobe, and pin reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_reg   <= 3'h0;
      pin_s2_reg   <= 3'h0;
      strap_s1_reg <= 2'h0;
      strap_s2_reg <= 2'h0;
    end else begin
      pin_s1_reg   <= {reset_n_pin, rw_rd_n, ce_n};
      pin_s2_reg   <= pin_s1_reg;
      strap_s1_reg <= {m68_sel, par_sel};
      strap_s2_reg <= strap_s1_reg;
    end
  end

  // ****************************************************************
  // Received byte and status
  // ****************************************************************
  logic       en_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic       rx_dc_reg;
  logic       valid_reg;
  logic       ovr_reg;
  lhp_src_t   src_reg;
  logic       new_byte;
  logic [7:0] new_data;
  logic       new_dc;
  lhp_src_t   new_src;
  logic       wr_acc;
  logic       rd_acc;
  logic       pin_rst;

  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & penable & ~pwrite;
  assign pin_rst = ~pin_s2_reg[2];

  // Pick the captured byte whose toggle moved, serial first.
  always_comb begin
    new_byte = en_reg & (|tog_evt);
    new_data = p68_byte_reg;
    new_dc   = p68_dc_reg;
    new_src  = LHP_SRC_P68;
    if (tog_evt[2]) begin
      new_data = ser_byte_reg;
      new_dc   = ser_dc_reg;
      new_src  = LHP_SRC_SER;
    end else if (tog_evt[1]) begin
      new_data = p80_byte_reg;
      new_dc   = p80_dc_reg;
      new_src  = LHP_SRC_P80;
    end
  end

  // A new byte wins over a pop of the received word in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_reg    <= 8'h00;
      rx_dc_reg <= 1'b0;
      valid_reg <= 1'b0;
      src_reg   <= LHP_SRC_NONE;
    end else if (pin_rst) begin
      valid_reg <= 1'b0;
      src_reg   <= LHP_SRC_NONE;
    end else if (new_byte) begin
      rx_reg    <= new_data;
      rx_dc_reg <= new_dc;
      valid_reg <= 1'b1;
      src_reg   <= new_src;
    end else if (rd_acc && paddr == LHP_RXDATA_OFF) begin
      valid_reg <= 1'b0;
    end
  end

  // Overrun is sticky; writing one clears it unless a new one arrives.
  // The pin reset wins, so the toggle drop it causes cannot set it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_reg <= 1'b0;
    end else if (pin_rst) begin
      ovr_reg <= 1'b0;
    end else if (new_byte && valid_reg) begin
      ovr_reg <= 1'b1;
    end else if (wr_acc && paddr == LHP_STATUS_OFF &&
                 pwdata[LHP_ST_OVR_BIT]) begin
      ovr_reg <= 1'b0;
    end
  end

  // Software control: capture enable and the byte the host reads.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= LHP_CTRL_RST;
      tx_reg <= LHP_TXDATA_RST;
    end else begin
      if (wr_acc && paddr == LHP_CTRL_OFF) begin
        en_reg <= pwdata[LHP_CTRL_EN_BIT];
      end
      if (wr_acc && paddr == LHP_TXDATA_OFF) begin
        tx_reg <= pwdata[7:0];
      end
    end
  end

  // ****************************************************************
  // Host read drive
  // ****************************************************************
  // The pins are driven on a 6800-style read or a low 80-style read strobe.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_oe  <= 1'b0;
      d_out <= 8'h00;
    end else begin
      d_out <= tx_reg;
      d_oe  <= strap_s2_reg[0] & ~pin_s2_reg[0] &
               (strap_s2_reg[1] ? pin_s2_reg[1] : ~pin_s2_reg[1]);
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign pready = 1'b1;

  // Unmapped addresses read zero and flag an error.
  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    case (paddr)
      LHP_CTRL_OFF: begin
        prdata[LHP_CTRL_EN_BIT] = en_reg;
      end
      LHP_STATUS_OFF: begin
        prdata[LHP_ST_VALID_BIT]  = valid_reg;
        prdata[LHP_ST_DC_BIT]     = rx_dc_reg;
        prdata[LHP_ST_OVR_BIT]    = ovr_reg;
        prdata[LHP_ST_PAR_BIT]    = strap_s2_reg[0];
        prdata[LHP_ST_M68_BIT]    = strap_s2_reg[1];
        prdata[LHP_ST_PINRST_BIT] = pin_rst;
        prdata[7:6]               = src_reg;
      end
      LHP_RXDATA_OFF: begin
        prdata[7:0] = rx_reg;
      end
      LHP_TXDATA_OFF: begin
        prdata[7:0] = tx_reg;
      end
      default: begin
        pslverr = psel & penable;
      end
    endcase
  end

endmodule // lhp_port
`default_nettype wire

// ---- pkg/lhp_pkg.sv ----
// Constants shared by the LCD host port select block.
package lhp_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] LHP_CTRL_OFF   = 8'h00;
  localparam logic [7:0] LHP_STATUS_OFF = 8'h04;
  localparam logic [7:0] LHP_RXDATA_OFF = 8'h08;
  localparam logic [7:0] LHP_TXDATA_OFF = 8'h0C;

  // ****************************************************************
  // Field positions, reset values and the last serial bit count
  // ****************************************************************
  localparam int LHP_CTRL_EN_BIT    = 0;
  localparam int LHP_ST_VALID_BIT   = 0;
  localparam int LHP_ST_DC_BIT      = 1;
  localparam int LHP_ST_OVR_BIT     = 2;
  localparam int LHP_ST_PAR_BIT     = 3;
  localparam int LHP_ST_M68_BIT     = 4;
  localparam int LHP_ST_PINRST_BIT  = 5;
  localparam logic       LHP_CTRL_RST   = 1'b0;
  localparam logic [7:0] LHP_TXDATA_RST = 8'h00;
  localparam logic [2:0] LHP_SER_LAST   = 3'h7;

  // Source of the most recently accepted byte.
  typedef enum logic [1:0] {LHP_SRC_NONE, LHP_SRC_P68, LHP_SRC_P80,
                            LHP_SRC_SER} lhp_src_t;

endpackage : lhp_pkg

// ---- tb/lhp_host_model.sv ----
// Host controller model that drives the LCD port link pins.
`timescale 1ns/100ps
`default_nettype none
module lhp_host_model (
  input  wire logic       par_sel,  // Strap copy.
  input  wire logic       m68_sel,  // Strap copy.
  output var  logic       link_clk, // Strobe, rests high.
  output var  logic       ce_n,     // Chip select.
  output var  logic       dc_pin,   // Data or command.
  output var  logic       rw_rd_n,  // Direction pin.
  output var  logic [7:0] d_in      // Data pins.
);
  // Pins start idle and deselected.
  initial begin
    link_clk <= 1'b1;
    ce_n <= 1'b1;
    dc_pin <= 1'b0;
    rw_rd_n <= 1'b1;
    d_in <= 8'hFF;
  end
  // One strobe; data is valid only around the latching edge.
  task automatic pulse(input logic [7:0] v, input logic early);
    d_in <= early ? v : ~v;
    #62.5 link_clk <= 1'b0;
    #31.0 d_in <= early ? ~v : v;
    #31.5 link_clk <= 1'b1;
  endtask
  // Sends one byte; cs low leaves the device deselected.
  // The closing gap keeps two sends from driving d_in in one step.
  task automatic send(input logic cs, input logic dc, input logic [7:0] b);
    ce_n <= ~cs;
    dc_pin <= dc;
    rw_rd_n <= ~m68_sel;
    if (par_sel) pulse(b, m68_sel);
    else for (int i = 7; i >= 0; i--)
      pulse({{7{~b[i]}}, b[i]}, 1'b1);
    #62.5 ce_n <= 1'b1;
    rw_rd_n <= 1'b1;
    #62.5 d_in <= ~d_in;
    #62.5;
  endtask
  // Opens or closes a read cycle.
  task automatic rd(input logic on);
    rw_rd_n <= on ? m68_sel : 1'b1;
    ce_n <= ~on;
  endtask
endmodule // lhp_host_model
`default_nettype wire

// ---- tb/lhp_port_monitor.sv ----
// Checker of the LCD host port pins and status word.
`timescale 1ns/100ps
`default_nettype none
module lhp_port_monitor
  import lhp_pkg::*;
(
  input wire logic        pclk,        // Clock.
  input wire logic        presetn,     // Reset.
  input wire logic        psel,        // Select.
  input wire logic        penable,     // Access.
  input wire logic        pwrite,      // Direction.
  input wire logic [7:0]  paddr,       // Address.
  input wire logic [31:0] prdata,      // Read data.
  input wire logic        reset_n_pin, // Pin reset.
  input wire logic        par_sel,     // Strap.
  input wire logic        m68_sel,     // Strap.
  input wire logic        ce_n,        // Chip select.
  input wire logic        rw_rd_n,     // Direction pin.
  input wire logic        d_oe         // Drive enable.
);
  // A selected parallel port and a status read.
  wire logic act = !ce_n && reset_n_pin && par_sel;
  wire logic st = psel && penable && !pwrite && paddr == LHP_STATUS_OFF;
  // All checks use the bus clock and reset.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Settled straps show in the status word.
  strap_par_a: assert property (
    st && $past(par_sel, 4) == par_sel |-> prdata[LHP_ST_PAR_BIT] == par_sel)
    else $error("Parallel strap bit wrong.");
  strap_m68_a: assert property (
    st && $past(m68_sel, 4) == m68_sel |-> prdata[LHP_ST_M68_BIT] == m68_sel)
    else $error("Bus family strap bit wrong.");
  // The data pins are driven only for a selected read.
  m68_rd_a: assert property (
    (act && m68_sel && rw_rd_n) [*6] |-> d_oe)
    else $error("6800 read not driven.");
  m68_wr_a: assert property (
    (act && m68_sel && !rw_rd_n) [*6] |-> !d_oe)
    else $error("6800 write driven.");
  i80_rd_a: assert property (
    (act && !m68_sel && !rw_rd_n) [*6] |-> d_oe)
    else $error("80 read not driven.");
  i80_wr_a: assert property (
    (act && !m68_sel && rw_rd_n) [*6] |-> !d_oe)
    else $error("80 write driven.");
  ser_quiet_a: assert property (
    (!par_sel) [*6] |-> !d_oe)
    else $error("Serial mode drove pins.");
  cs_off_a: assert property (
    ce_n [*6] |-> !d_oe)
    else $error("Pins driven while deselected.");
  // Main scenarios reached.
  cover property (st && prdata[LHP_ST_VALID_BIT]);
  cover property (st && prdata[LHP_ST_OVR_BIT]);
  cover property (d_oe);
endmodule // lhp_port_monitor

bind lhp_port lhp_port_monitor u_lhp_port_monitor (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .reset_n_pin(reset_n_pin),
  .par_sel(par_sel), .m68_sel(m68_sel), .ce_n(ce_n), .rw_rd_n(rw_rd_n),
  .d_oe(d_oe));
`default_nettype wire

// ---- tb/lhp_port_tb_top.sv ----
// Testbench of the LCD host port with APB tasks and a host model.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin miscompares++; \
  $display("[ERR] %0t %h %h", $time, g, x); end end
module lhp_port_tb_top
  import lhp_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, reset_n_pin = 1'b1, par_sel = 1'b1;
  logic        m68_sel = 1'b1, pready, pslverr, e, link_clk, ce_n;
  logic        dc_pin, rw_rd_n, d_oe;
  logic [7:0]  paddr = 8'h00, d_in, d_out, b;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [1:0]  src;
  int          miscompares = 0, checked = 0, cyc = 0;
  // Bus clock.
  always #4 pclk = ~pclk;
  lhp_port u_lhp_port (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .reset_n_pin(reset_n_pin), .par_sel(par_sel),
    .m68_sel(m68_sel), .dc_pin(dc_pin), .ce_n(ce_n), .rw_rd_n(rw_rd_n),
    .d_in(d_in), .d_out(d_out), .d_oe(d_oe));
  lhp_host_model u_lhp_host_model (.par_sel(par_sel), .m68_sel(m68_sel),
    .link_clk(link_clk), .ce_n(ce_n), .dc_pin(dc_pin), .rw_rd_n(rw_rd_n),
    .d_in(d_in));
  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (miscompares == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One APB transfer; read data and error land in r and e.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Cuts a hang short.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  // Each mode in turn: straps move only under reset.
  initial begin
    for (int m = 0; m < 3; m++) begin
      presetn <= 1'b0;
      par_sel <= m < 2;
      m68_sel <= m == 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      src = 2'(m + 1);
      apb(1'b0, LHP_CTRL_OFF, 32'h0);
      `CHK(r, {31'h0, LHP_CTRL_RST})
      apb(1'b0, LHP_TXDATA_OFF, 32'h0);
      `CHK(r, {24'h0, LHP_TXDATA_RST})
      apb(1'b1, LHP_CTRL_OFF, 32'h1);
      u_lhp_host_model.send(1'b0, 1'b1, 8'h3C);
      apb(1'b0, LHP_STATUS_OFF, 32'h0);
      `CHK(r, {27'h0, m68_sel, par_sel, 3'h0})
      for (int k = 0; k < 2; k++) begin
        b = 8'(8'hA5 + 8'h12 * m + k);
        u_lhp_host_model.send(1'b1, k[0], b);
        apb(1'b0, LHP_STATUS_OFF, 32'h0);
        `CHK(r, {24'h0, src, 1'b0, m68_sel, par_sel, 1'b0, k[0], 1'b1})
        apb(1'b0, LHP_RXDATA_OFF, 32'h0);
        `CHK(r, {24'h0, b})
      end
      u_lhp_host_model.send(1'b1, 1'b1, 8'h11);
      u_lhp_host_model.send(1'b1, 1'b1, 8'h22);
      apb(1'b0, LHP_STATUS_OFF, 32'h0);
      `CHK(r[2:0], 3'h7)
      apb(1'b0, LHP_RXDATA_OFF, 32'h0);
      `CHK(r[7:0], 8'h22)
      apb(1'b1, LHP_STATUS_OFF, 32'h4);
      apb(1'b0, LHP_STATUS_OFF, 32'h0);
      `CHK(r[2:0], 3'h2)
      if (m < 2) begin
        apb(1'b1, LHP_TXDATA_OFF, {24'h0, ~b});
        u_lhp_host_model.rd(1'b1);
        repeat (6) @(posedge pclk);
        `CHK({d_oe, d_out}, {1'b1, ~b})
        u_lhp_host_model.rd(1'b0);
        repeat (6) @(posedge pclk);
        `CHK(d_oe, 1'b0)
      end
    end
    u_lhp_host_model.send(1'b1, 1'b0, 8'h5A);
    @(posedge pclk);
    reset_n_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, LHP_STATUS_OFF, 32'h0);
    `CHK({r[5], r[0]}, 2'b10)
    reset_n_pin <= 1'b1;
    apb(1'b0, 8'h10, 32'h0);
    `CHK({e, r}, {1'b1, 32'h0})
    wrap_up();
  end
endmodule // lhp_port_tb_top
`default_nettype wire
